/* File: rtl/chr_consts.svh */
/*
 * Offsets, address ranges, field codes and timing figures of the carrier host register block.
 * Assumes it is included by bare name from files that need the named values.
 */
`ifndef CHR_CONSTS_SVH
`define CHR_CONSTS_SVH

// ----------------------------------------------------------------
// I/O window register offsets
// ----------------------------------------------------------------
`define CHR_IO_DATA 8'h10
`define CHR_IO_CTRL 8'h14
`define CHR_IO_IRQC 8'h18
`define CHR_IO_IRQEN 8'h40
`define CHR_IO_CLK23 8'h60
`define CHR_IO_CLK4 8'h64
`define CHR_IRQEN_MASK 16'h0007
`define CHR_IRQ_LINES 3
// ----------------------------------------------------------------
// Memory window
// ----------------------------------------------------------------
`define CHR_SRAM_LAST 32'h000FFFFF
`define CHR_MIR_DATA 32'h00200090
`define CHR_MIR_CTRL 32'h00200094
`define CHR_MIR_IRQC 32'h00200098
`define CHR_MIR_DELTA 8'h80
`define CHR_GBUS_FIRST 32'h00200000
`define CHR_GBUS_LAST 32'h0020007F
`define CHR_GBUS_HIGH 32'h40080000
`define CHR_GBUS_LOW 32'h000000A0
`define CHR_PLD_FIRST 32'h00200240
`define CHR_PLD_LAST 32'h0020025F
`define CHR_PLC_FIRST 32'h00200260
`define CHR_PLC_LAST 32'h0020027F
`define CHR_DMA_BIT 28
// The DMA select line counts 32-bit words, so on the byte address it sits two bits higher.
`define CHR_DMA_BYTE_BIT (`CHR_DMA_BIT + 2)
`define CHR_DMA_BASE 32'h40000000
// ----------------------------------------------------------------
// Module-side local bus map
// ----------------------------------------------------------------
`define CHR_AP0_FIRST 32'h18000000
`define CHR_AP0_LAST 32'h183FFFFF
`define CHR_AP1_FIRST 32'h14000000
`define CHR_AP1_LAST 32'h17FFFFFF
`define CHR_BRG_FIRST 32'h1C000000
`define CHR_BRG_LAST 32'h1C0000FF
`define CHR_LSRAM_FIRST 32'hD0000000
`define CHR_LSRAM_LAST 32'hD00FFFFF
`define CHR_MBOX_FIRST 8'hC0
`define CHR_MBOX_LAST 8'hCF
// ----------------------------------------------------------------
// Clock select codes and timing
// ----------------------------------------------------------------
`define CHR_CODE_A 4'h5
`define CHR_CODE_B 4'h7
`define CHR_CODE_C 4'hD
`define CHR_CODE_D 4'hF
`define CHR_DIV_A 4'h1
`define CHR_DIV_B 4'h3
`define CHR_DIV_C 4'h8
`define CHR_DIV_D 4'hC
`define CHR_PH2_A 5'h1C
`define CHR_PH2_B 5'h1E
`define CHR_PH2_C 5'h02
`define CHR_PH2_D 5'h04
`define CHR_PH34_A 5'h18
`define CHR_PH34_B 5'h1A
`define CHR_PH34_C 5'h06
`define CHR_PH34_D 5'h08
`define CHR_CLK_PERIOD_PS 5000
`define CHR_REF_PERIOD_PS 10000
`define CHR_PHASE_N 16
`define CHR_PHASE_STEP_PS (`CHR_REF_PERIOD_PS / `CHR_PHASE_N)
`define CHR_HALF_CYC (`CHR_REF_PERIOD_PS / (2 * `CHR_CLK_PERIOD_PS))

`endif

/* File: rtl/chr_pkg.sv */
/*
 * Types shared by the carrier host register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package chr_pkg;

	// ------------------------------------------------------------
	// Host access as delivered by the bridge
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic ioSpace;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} chr_host_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} chr_host_rsp_t;

	// Access forwarded to a resource outside this block.
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} chr_mem_req_t;

	// One clock bank setting: frequency code above phase code.
	typedef struct packed {
		logic [3:0] freqSel;
		logic [3:0] phaseSel;
	} chr_clk_cfg_t;

endpackage : chr_pkg

/* File: rtl/chr_host_regs.sv */
/*
 * Carrier host register bank: I/O window registers, memory window decode,
 * local bus decode, shared interrupt lines and three programmable module clocks.
 * Assumes host accesses arrive as single-cycle requests on ref_clk and that
 * the forwarded resources (SRAM, global bus, parallel link) answer the host themselves.
 */
`include "chr_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module chr_host_regs (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Host access through the bridge
	input wire chr_pkg::chr_host_req_t hostReq,
	output chr_pkg::chr_host_rsp_t hostRsp,
	// Link data port and board control/status
	input wire logic [31:0] comportIn,
	input wire logic [31:0] boardStatus,
	output logic [31:0] comportOut,
	output logic comportWrStrobe,
	output logic comportRdStrobe,
	output logic [31:0] boardControl,
	output logic [31:0] irqSetup,
	// Shared open-collector DSP interrupt lines
	input wire logic [2:0] dspIrqIn,
	output logic [2:0] dspIrqOut,
	output logic [2:0] dspIrqOe,
	// Forwarded memory window accesses
	output chr_pkg::chr_mem_req_t sramReq,
	output chr_pkg::chr_mem_req_t gbusReq,
	output chr_pkg::chr_mem_req_t plDataReq,
	output chr_pkg::chr_mem_req_t plCtrlReq,
	// Module-side local bus
	input wire logic lbValid,
	input wire logic [31:0] lbAddr,
	input wire logic mailboxIrqEnable,
	output logic [3:0] lbSel,
	output logic mboxHostIrq,
	// Programmable module clocks, index 0 is bank 2
	output logic [2:0] moduleClk,
	output logic [2:0] clkCodeValid,
	output logic [2:0][4:0] phaseSteps
);
	import chr_pkg::*;

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [15:0] irqEnReg;
	logic [15:0] clk23Reg;
	logic [7:0] clk4Reg;
	logic [7:0] regOff;
	logic regAcc;
	logic memAcc;
	logic dmaHit;
	logic sramHit;
	logic gbusHit;
	logic pldHit;
	logic plcHit;
	logic [31:0] dmaAddr;
	logic wrStb;
	logic rdStb;
	logic [31:0] readMux;
	chr_clk_cfg_t bankCfg [3];
	logic [2:0] cfgWrite;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------

	// The mirrors sit 80 hex above the I/O offsets, so one subtraction folds them in.
	always_comb begin
		memAcc = hostReq.valid && !hostReq.ioSpace;
		regOff = hostReq.addr[7:0];
		regAcc = 1'b0;
		if (hostReq.valid && hostReq.ioSpace && hostReq.addr[31:8] == 24'h000000) begin
			regAcc = 1'b1;
		end else if (memAcc && (hostReq.addr == `CHR_MIR_DATA || hostReq.addr == `CHR_MIR_CTRL
			|| hostReq.addr == `CHR_MIR_IRQC)) begin
			regAcc = 1'b1;
			regOff = hostReq.addr[7:0] - `CHR_MIR_DELTA;
		end
	end

	// DMA sees SRAM with address line 28 high; that line counts words, so it is byte
	// address bit 30. Subtract the base to reach the array.
	assign dmaAddr = hostReq.addr - `CHR_DMA_BASE;
	assign dmaHit = memAcc && hostReq.addr[`CHR_DMA_BYTE_BIT]
		&& dmaAddr <= `CHR_SRAM_LAST;
	assign sramHit = (memAcc && hostReq.addr <= `CHR_SRAM_LAST) || dmaHit;
	assign gbusHit = memAcc && hostReq.addr >= `CHR_GBUS_FIRST && hostReq.addr <= `CHR_GBUS_LAST
		&& !regAcc;
	assign pldHit = memAcc && hostReq.addr >= `CHR_PLD_FIRST && hostReq.addr <= `CHR_PLD_LAST;
	assign plcHit = memAcc && hostReq.addr >= `CHR_PLC_FIRST && hostReq.addr <= `CHR_PLC_LAST;
	assign wrStb = regAcc && hostReq.write;
	assign rdStb = regAcc && !hostReq.write;

	// ------------------------------------------------------------
	// Host-writable registers
	// ------------------------------------------------------------

	// Reserved enable bits are never stored, so they cannot read back as one.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irqEnReg <= 16'h0000;
		end else if (wrStb && regOff == `CHR_IO_IRQEN) begin
			irqEnReg <= hostReq.wdata[15:0] & `CHR_IRQEN_MASK;
		end
	end

	// Clock registers hold any value written, listed code or not.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			clk23Reg <= 16'h0000;
			clk4Reg <= 8'h00;
		end else if (wrStb && regOff == `CHR_IO_CLK23) begin
			clk23Reg <= hostReq.wdata[15:0];
		end else if (wrStb && regOff == `CHR_IO_CLK4) begin
			clk4Reg <= hostReq.wdata[7:0];
		end
	end

	// Link data, control and interrupt setup; the data write also strobes the port.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			comportOut <= 32'h00000000;
			boardControl <= 32'h00000000;
			irqSetup <= 32'h00000000;
			comportWrStrobe <= 1'b0;
			comportRdStrobe <= 1'b0;
		end else begin
			comportWrStrobe <= wrStb && regOff == `CHR_IO_DATA;
			comportRdStrobe <= rdStb && regOff == `CHR_IO_DATA;
			if (wrStb && regOff == `CHR_IO_DATA) begin
				comportOut <= hostReq.wdata;
			end
			if (wrStb && regOff == `CHR_IO_CTRL) begin
				boardControl <= hostReq.wdata;
			end
			if (wrStb && regOff == `CHR_IO_IRQC) begin
				irqSetup <= hostReq.wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Host answer
	// ------------------------------------------------------------

	// Interrupt setup is write-only; every unassigned offset reads as zero.
	always_comb begin
		case (regOff)
			`CHR_IO_DATA: readMux = comportIn;
			`CHR_IO_CTRL: readMux = boardStatus;
			`CHR_IO_IRQEN: readMux = {16'h0000, irqEnReg};
			`CHR_IO_CLK23: readMux = {16'h0000, clk23Reg};
			`CHR_IO_CLK4: readMux = {24'h000000, clk4Reg};
			default: readMux = 32'h00000000;
		endcase
	end

	// Forwarded regions are answered by their own resource, not here.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			hostRsp <= '0;
		end else begin
			hostRsp.ack <= hostReq.valid && !(sramHit || gbusHit || pldHit || plcHit);
			hostRsp.rdata <= rdStb ? readMux : 32'h00000000;
		end
	end

	// ------------------------------------------------------------
	// Forwarded memory window accesses
	// ------------------------------------------------------------

	// Global bus addresses carry the select bits the module decodes.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sramReq <= '0;
			gbusReq <= '0;
			plDataReq <= '0;
			plCtrlReq <= '0;
		end else begin
			sramReq <= '{sramHit, hostReq.write, dmaHit ? dmaAddr : hostReq.addr,
				hostReq.wdata};
			gbusReq <= '{gbusHit, hostReq.write,
				(hostReq.addr | `CHR_GBUS_HIGH) & ~`CHR_GBUS_LOW, hostReq.wdata};
			plDataReq <= '{pldHit, hostReq.write, hostReq.addr,
				{16'h0000, hostReq.wdata[15:0]}};
			plCtrlReq <= '{plcHit, hostReq.write, hostReq.addr, hostReq.wdata};
		end
	end

	// ------------------------------------------------------------
	// Local bus decode and mailbox interrupt
	// ------------------------------------------------------------

	// Select bits: 0 aperture 0, 1 aperture 1, 2 bridge registers, 3 shared SRAM.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			lbSel <= 4'h0;
			mboxHostIrq <= 1'b0;
		end else begin
			lbSel[0] <= lbValid && lbAddr >= `CHR_AP0_FIRST && lbAddr <= `CHR_AP0_LAST;
			lbSel[1] <= lbValid && lbAddr >= `CHR_AP1_FIRST && lbAddr <= `CHR_AP1_LAST;
			lbSel[2] <= lbValid && lbAddr >= `CHR_BRG_FIRST && lbAddr <= `CHR_BRG_LAST;
			lbSel[3] <= lbValid && lbAddr >= `CHR_LSRAM_FIRST
				&& lbAddr <= `CHR_LSRAM_LAST;
			mboxHostIrq <= lbValid && mailboxIrqEnable && lbAddr[31:8] == `CHR_BRG_FIRST >> 8
				&& lbAddr[7:0] >= `CHR_MBOX_FIRST && lbAddr[7:0] <= `CHR_MBOX_LAST;
		end
	end

	// ------------------------------------------------------------
	// Shared interrupt lines
	// ------------------------------------------------------------

	// The host only ever pulls low; the DSP may pull the same wire at any time.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			dspIrqOe <= 3'h0;
			dspIrqOut <= 3'h0;
		end else begin
			dspIrqOe <= irqSetup[2:0] & irqEnReg[2:0];
			dspIrqOut <= 3'h0;
		end
	end

	// ------------------------------------------------------------
	// Module clock generation
	// ------------------------------------------------------------

	assign bankCfg[0] = clk23Reg[7:0];
	assign bankCfg[1] = clk23Reg[15:8];
	assign bankCfg[2] = clk4Reg;
	assign cfgWrite[0] = wrStb && regOff == `CHR_IO_CLK23;
	assign cfgWrite[1] = cfgWrite[0];
	assign cfgWrite[2] = wrStb && regOff == `CHR_IO_CLK4;

	// Divider from a frequency code; zero marks an undefined code.
	function automatic logic [3:0] chr_div(input logic [3:0] code);
		case (code)
			`CHR_CODE_A: chr_div = `CHR_DIV_A;
			`CHR_CODE_B: chr_div = `CHR_DIV_B;
			`CHR_CODE_C: chr_div = `CHR_DIV_C;
			`CHR_CODE_D: chr_div = `CHR_DIV_D;
			default: chr_div = 4'h0;
		endcase
	endfunction : chr_div

	// Signed phase in steps of the reference over sixteen.
	function automatic logic [4:0] chr_phase(input logic [3:0] code, input logic bankTwo);
		case (code)
			`CHR_CODE_A: chr_phase = bankTwo ? `CHR_PH2_A : `CHR_PH34_A;
			`CHR_CODE_B: chr_phase = bankTwo ? `CHR_PH2_B : `CHR_PH34_B;
			`CHR_CODE_C: chr_phase = bankTwo ? `CHR_PH2_C : `CHR_PH34_C;
			`CHR_CODE_D: chr_phase = bankTwo ? `CHR_PH2_D : `CHR_PH34_D;
			default: chr_phase = 5'h00;
		endcase
	endfunction : chr_phase

	// Each bank toggles after div half-periods of the reference; a write restarts it
	// low so a new setting never produces a runt high phase. Sub-cycle phase (625 ps)
	// is finer than this clock, so the step count is presented for the output delay line.
	for (genvar b = 0; b < 3; b++) begin : g_bank
		logic [3:0] divCnt;
		logic [3:0] divHalf;
		assign divHalf = 4'(chr_div(bankCfg[b].freqSel) * `CHR_HALF_CYC);
		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn) begin
				divCnt <= 4'h0;
				moduleClk[b] <= 1'b0;
				clkCodeValid[b] <= 1'b0;
				phaseSteps[b] <= 5'h00;
			end else begin
				clkCodeValid[b] <= divHalf != 4'h0 && chr_div(bankCfg[b].phaseSel) != 4'h0;
				phaseSteps[b] <= chr_phase(bankCfg[b].phaseSel, b == 0);
				if (cfgWrite[b] || divHalf == 4'h0) begin
					divCnt <= 4'h0;
					moduleClk[b] <= 1'b0;
				end else if (divCnt == divHalf - 4'h1) begin
					divCnt <= 4'h0;
					moduleClk[b] <= ~moduleClk[b];
				end else begin
					divCnt <= divCnt + 4'h1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence s_enWrite;
		hostReq.valid && hostReq.ioSpace && hostReq.write && hostReq.addr == 32'(`CHR_IO_IRQEN);
	endsequence
	sequence s_mirrorWrite;
		hostReq.valid && !hostReq.ioSpace && hostReq.write && hostReq.addr == `CHR_MIR_DATA;
	endsequence

	chk_enable_reserved: assert property (irqEnReg[15:3] == 13'h0000)
		else $error("Reserved enable bits set.");
	chk_enable_write: assert property (s_enWrite |=> hostRsp.ack
		&& irqEnReg == ($past(hostReq.wdata[15:0]) & `CHR_IRQEN_MASK))
		else $error("Enable register write not taken.");
	chk_mirror_alias: assert property (s_mirrorWrite |=> comportWrStrobe
		&& comportOut == $past(hostReq.wdata))
		else $error("Data mirror did not reach link port.");
	chk_unmapped_zero: assert property (hostReq.valid && hostReq.ioSpace && !hostReq.write
		&& hostReq.addr == 32'h0000001C |=> hostRsp.ack && hostRsp.rdata == 32'h00000000)
		else $error("Unassigned offset read nonzero.");
	chk_sram_range: assert property (memAcc && hostReq.addr <= `CHR_SRAM_LAST
		|=> sramReq.valid && sramReq.addr == $past(hostReq.addr) && !hostRsp.ack)
		else $error("SRAM access not forwarded.");
	chk_dma_offset: assert property (memAcc && hostReq.addr >= `CHR_DMA_BASE
		&& hostReq.addr <= `CHR_DMA_BASE + `CHR_SRAM_LAST
		|=> sramReq.valid && sramReq.addr == $past(hostReq.addr) - `CHR_DMA_BASE)
		else $error("DMA window did not map onto SRAM.");
	chk_gbus_bits: assert property (gbusReq.valid |-> gbusReq.addr[30] && gbusReq.addr[19]
		&& !gbusReq.addr[7] && !gbusReq.addr[5])
		else $error("Global bus select bits wrong.");
	chk_link_ranges: assert property (plDataReq.valid |-> !plCtrlReq.valid
		&& plDataReq.addr >= `CHR_PLD_FIRST && plDataReq.addr <= `CHR_PLD_LAST)
		else $error("Parallel link data decode wrong.");
	chk_local_bridge: assert property (lbValid && lbAddr == `CHR_BRG_FIRST
		|=> lbSel == 4'h4)
		else $error("Bridge register window not selected.");
	chk_irq_drive: assert property (dspIrqOe != 3'h0 |-> dspIrqOut == 3'h0
		&& (dspIrqOe & ~$past(irqEnReg[2:0])) == 3'h0)
		else $error("Interrupt line driven without enable.");
	chk_clk_fast: assert property (cfgWrite[0] && hostReq.wdata[7:4] == `CHR_CODE_A
		|=> !moduleClk[0] ##1 moduleClk[0] ##1 !moduleClk[0])
		else $error("Divide by one clock not toggling.");

endmodule : chr_host_regs
`default_nettype wire

/* File: test/chr_host_model.sv */
/*
 * Host-side model: issues single accesses to the register block the way the bridge does.
 * Assumes the bench calls access() hierarchically and one ref_clk drives both sides.
 */
`timescale 1ns/100ps
`default_nettype none

module chr_host_model (
	// Clock
	input wire logic ref_clk,
	// Bridge access
	output chr_pkg::chr_host_req_t hostReq,
	input wire chr_pkg::chr_host_rsp_t hostRsp
);
	import chr_pkg::*;

	// ------------------------------------------------------------
	// Access driver
	// ------------------------------------------------------------
	// Idle bus starts low, before the first access is made.
	initial hostReq = '0;

	// Valid stands for one edge, and the answer is taken one cycle later.
	// A released bus shows inverted fields so that stale values cannot be mistaken for live ones.
	task automatic access(input logic io, input logic wr, input logic [31:0] addr,
		input logic [31:0] wdata, output logic ack, output logic [31:0] rdata);
		@(negedge ref_clk);
		hostReq <= '{1'b1, io, wr, addr, wdata};
		@(negedge ref_clk);
		hostReq <= '{1'b0, ~io, ~wr, ~addr, ~wdata};
		ack = hostRsp.ack;
		rdata = hostRsp.rdata;
	endtask : access
endmodule : chr_host_model

`default_nettype wire

/* File: test/tb.sv */
/*
 * Self-checking bench for the carrier host register block.
 * Assumes the host model drives the bridge side and the bench drives every other input.
 */
`include "chr_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module tb;
	import chr_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	chr_host_req_t hostReq;
	chr_host_rsp_t hostRsp;
	logic [31:0] comportIn = 32'hA5C30F1E;
	logic [31:0] boardStatus = 32'h12345678;
	logic [31:0] comportOut, boardControl, irqSetup;
	logic comportWrStrobe, comportRdStrobe, mboxHostIrq;
	logic lbValid = 1'b0;
	logic [31:0] lbAddr = 32'h0;
	logic mailboxIrqEnable = 1'b0;
	logic [2:0] dspIrqIn, dspIrqOut, dspIrqOe, moduleClk, clkCodeValid;
	logic [2:0] dspPull = 3'b100;
	logic [2:0][4:0] phaseSteps;
	logic [3:0] lbSel;
	chr_mem_req_t sramReq, gbusReq, plDataReq, plCtrlReq, mr;
	logic lastAck;
	logic [31:0] lastData, base, v;
	int errors = 0;
	int cmp_count = 0;
	int n;

	// Clock at 200 MHz.
	always #2.5 ref_clk = ~ref_clk;

	// Shared lines are pulled up and pulled low by whichever side enables.
	assign dspIrqIn = ~(dspIrqOe | dspPull);

	chr_host_regs chr_host_regs_i (.ref_clk(ref_clk), .resetn(resetn), .hostReq(hostReq),
		.hostRsp(hostRsp), .comportIn(comportIn), .boardStatus(boardStatus),
		.comportOut(comportOut), .comportWrStrobe(comportWrStrobe),
		.comportRdStrobe(comportRdStrobe), .boardControl(boardControl), .irqSetup(irqSetup),
		.dspIrqIn(dspIrqIn), .dspIrqOut(dspIrqOut), .dspIrqOe(dspIrqOe), .sramReq(sramReq),
		.gbusReq(gbusReq), .plDataReq(plDataReq), .plCtrlReq(plCtrlReq), .lbValid(lbValid),
		.lbAddr(lbAddr), .mailboxIrqEnable(mailboxIrqEnable), .lbSel(lbSel),
		.mboxHostIrq(mboxHostIrq), .moduleClk(moduleClk), .clkCodeValid(clkCodeValid),
		.phaseSteps(phaseSteps));

	chr_host_model chr_host_model_i (.ref_clk(ref_clk), .hostReq(hostReq), .hostRsp(hostRsp));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Comparison with case inequality, so an unknown never passes.
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic acc(input logic io, input logic w, input logic [31:0] a, input logic [31:0] d);
		chr_host_model_i.access(io, w, a, d, lastAck, lastData);
	endtask : acc

	task automatic wr(input logic io, input logic [31:0] a, input logic [31:0] d);
		acc(io, 1'b1, a, d);
		check(lastAck, 1, "write ack");
	endtask : wr

	task automatic rd(input logic io, input logic [31:0] a, input logic [31:0] exp);
		acc(io, 1'b0, a, 32'h0);
		check(lastAck, 1, "read ack");
		check(lastData, exp, "read data");
	endtask : rd

	// Length of one high phase of a module clock, in reference cycles.
	task automatic high_len(input int b, output int len);
		int k;
		len = 0;
		// Skip a high phase already under way, so only a whole one is measured.
		for (k = 0; k < 40 && moduleClk[b] === 1'b1; k++) @(negedge ref_clk);
		for (k = 0; k < 40 && moduleClk[b] !== 1'b1; k++) @(negedge ref_clk);
		for (k = 0; k < 40 && moduleClk[b] === 1'b1; k++) begin
			len++;
			@(negedge ref_clk);
		end
	endtask : high_len

	task automatic end_sim;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// Watchdog sized well above the expected run of a few hundred cycles.
	initial begin
		#100000;
		errors++;
		end_sim();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		logic [31:0] fa[9] = '{32'h1234, 32'hFFFFC, 32'h40000010, 32'h200004, 32'h20007F,
			32'h200240, 32'h20025F, 32'h200260, 32'h20027F};
		logic [31:0] fx[9] = '{32'h1234, 32'hFFFFC, 32'h10, 32'h40280004, 32'h4028005F,
			32'h200240, 32'h20025F, 32'h200260, 32'h20027F};
		int fs[9] = '{0, 0, 0, 1, 1, 2, 2, 3, 3};
		logic [31:0] la[12] = '{32'h14000000, 32'h17FFFFFF, 32'h18000000, 32'h183FFFFF,
			32'h18400000, 32'h1C000000, 32'h1C0000C0, 32'h1C0000CF, 32'h1C0000D0,
			32'h1C000100, 32'hD0000000, 32'hD00FFFFF};
		logic [4:0] le[12] = '{2, 2, 1, 1, 0, 4, 20, 20, 4, 0, 8, 8};
		logic [31:0] ua[8] = '{0, 32'h1C, 32'h20, 32'h3C, 32'h44, 32'h80, 32'hAC, 32'h100};
		logic [3:0] cd[4] = '{4'h5, 4'h7, 4'hD, 4'hF};
		int dv[4] = '{1, 3, 8, 12};
		logic [4:0] p2[4] = '{5'h1C, 5'h1E, 5'h02, 5'h04};
		logic [4:0] p34[4] = '{5'h18, 5'h1A, 5'h06, 5'h08};
		repeat (16) @(negedge ref_clk);
		resetn = 1'b1;
		// Enables keep three bits; clock registers keep their widths.
		wr(1, 32'h40, 32'hFFFFFFFF);
		rd(1, 32'h40, 32'h7);
		wr(1, 32'h60, 32'hFFFF5A7D);
		rd(1, 32'h60, 32'h5A7D);
		wr(1, 32'h64, 32'hFFFF5A7D);
		rd(1, 32'h64, 32'h7D);
		// Link registers, through the I/O window and through the memory mirrors.
		for (int sp = 0; sp < 2; sp++) begin
			base = sp ? 32'h10 : `CHR_MIR_DATA;
			v = 32'h13579BD0 + sp;
			wr(sp[0], base, v);
			check(comportWrStrobe, 1, "wr strobe");
			check(comportOut, v, "link out");
			wr(sp[0], base + 4, ~v);
			check(boardControl, ~v, "control");
			wr(sp[0], base + 8, v ^ 32'hF);
			check(irqSetup, v ^ 32'hF, "irq setup");
			rd(sp[0], base, comportIn);
			check(comportRdStrobe, 1, "rd strobe");
			rd(sp[0], base + 4, boardStatus);
			rd(sp[0], base + 8, 0);
		end
		// Unassigned offsets answer zero and leave the enables alone.
		foreach (ua[i]) begin
			wr(1, ua[i], 32'hFFFFFFFF);
			rd(1, ua[i], 0);
		end
		rd(1, 32'h40, 32'h7);
		// Forwarded memory window regions get no ack and one valid request.
		foreach (fa[i]) begin
			acc(0, 1'b1, fa[i], 32'hDEADBEEF);
			mr = fs[i] == 0 ? sramReq : fs[i] == 1 ? gbusReq : fs[i] == 2 ? plDataReq : plCtrlReq;
			check(lastAck, 0, "fwd ack");
			check({sramReq.valid, gbusReq.valid, plDataReq.valid, plCtrlReq.valid},
				4'h8 >> fs[i], "fwd select");
			check(mr.write, 1, "fwd write");
			check(mr.addr, fx[i], "fwd addr");
			if (fs[i] == 2) check(mr.wdata[15:0], 16'hBEEF, "link data");
		end
		// Host interrupts reach a line only where enabled, one cycle after the register.
		wr(1, 32'h18, 32'h5);
		@(negedge ref_clk);
		check(dspIrqOe, 3'h5, "line enables");
		check(dspIrqOut, 0, "line level");
		wr(1, 32'h40, 32'h1);
		@(negedge ref_clk);
		check(dspIrqOe, 3'h1, "masked line");
		// Local bus decode and mailbox host interrupt.
		mailboxIrqEnable = 1'b1;
		lbValid = 1'b1;
		foreach (la[i]) begin
			lbAddr = la[i];
			@(negedge ref_clk);
			check({mboxHostIrq, lbSel}, le[i], "local decode");
		end
		mailboxIrqEnable = 1'b0;
		lbAddr = 32'h1C0000C4;
		@(negedge ref_clk);
		check(mboxHostIrq, 0, "mailbox masked");
		lbValid = 1'b0;
		@(negedge ref_clk);
		check(lbSel, 0, "local idle");
		// Every listed code: divide ratio and phase steps of each bank.
		foreach (cd[i]) begin
			wr(1, 32'h60, {16'h0, cd[i], cd[i], cd[i], cd[i]});
			wr(1, 32'h64, {24'h0, cd[i], cd[i]});
			@(negedge ref_clk);
			check(clkCodeValid, 3'h7, "codes valid");
			check(phaseSteps[0], p2[i], "bank2 phase");
			check(phaseSteps[1], p34[i], "bank3 phase");
			check(phaseSteps[2], p34[i], "bank4 phase");
			for (int b = 0; b < 3; b++) begin
				high_len(b, n);
				check(n, dv[i], "clock half period");
			end
		end
		// Unlisted codes stop the clocks but the bank 2/3 clock register keeps what was written.
		wr(1, 32'h60, 32'h1234);
		wr(1, 32'h64, 32'h0);
		@(negedge ref_clk);
		check({clkCodeValid, phaseSteps}, 0, "undefined codes");
		v = 0;
		repeat (30) begin
			@(negedge ref_clk);
			v = v | moduleClk;
		end
		check(v, 0, "clocks held");
		rd(1, 32'h60, 32'h1234);
		// Second reset in mid-run clears the registers.
		resetn = 1'b0;
		@(negedge ref_clk);
		check({dspIrqOe, hostRsp.ack, clkCodeValid}, 0, "in reset");
		resetn = 1'b1;
		rd(1, 32'h40, 0);
		end_sim();
	end
endmodule : tb

`default_nettype wire
